/* File: rtl/isa_jumperless_config_reset.sv */
// jumperless setting register, io base cycling read and soft reset ports
`timescale 1ns/1ps
module isa_jumperless_config_reset
	import jumperless_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic isa_mode,
	input wire logic jumperless_mode,
	input wire logic init_load,
	input wire logic [1:0] init_irq_sel,
	input wire logic [2:0] init_io_sel,
	input wire logic [4:0] addr,
	input wire logic rd,
	input wire logic wr,
	output logic [7:0] rd_data,
	output logic soft_reset,
	output logic [1:0] irq_channel_sel,
	output logic [2:0] io_window_sel
);
	typedef struct packed {
		logic [1:0] irq_sel;
		logic [2:0] io_sel;
		logic [7:0] rdata;
		logic srst;
	} state_t;

	state_t cur_ff;
	state_t nxt_cur;

	// true when the address hits one of the eight reset ports
	function automatic logic is_reset_port(input logic [4:0] a);
		is_reset_port = (a[4:3] == soft_reset_page);
	endfunction

	// the cycling port; reading it is what steps the io window
	function automatic logic is_io_base(input logic [4:0] a);
		is_io_base = (a == io_base_cycling_addr);
	endfunction

	// the read-only setting register
	function automatic logic is_setting(input logic [4:0] a);
		is_setting = (a == jumperless_setting_addr);
	endfunction

	// selections are kept across soft reset; only hard reset clears them
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.srst = 1'b0;
		nxt_cur.rdata = 8'h00;
		if (init_load)
		begin
			nxt_cur.irq_sel = init_irq_sel;
			nxt_cur.io_sel = init_io_sel;
		end
		else if (rd && jumperless_mode && is_io_base(addr))
		begin
			nxt_cur.io_sel = cur_ff.io_sel + io_sel_step;
			nxt_cur.rdata = io_base_read_value;
		end
		else if (rd && is_setting(addr))
		begin
			nxt_cur.rdata = jumperless_setting_reset;
			nxt_cur.rdata[irq_sel_msb:irq_sel_lsb] = cur_ff.irq_sel;
			nxt_cur.rdata[io_sel_msb:io_sel_lsb] = cur_ff.io_sel;
		end
		// any data value triggers it; setting fields untouched
		if (wr && isa_mode && is_reset_port(addr))
			nxt_cur.srst = 1'b1;
	end

	// synchronous reset; clock enable freezes everything
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cur_ff.irq_sel <= irq_sel_reset;
			cur_ff.io_sel <= io_sel_reset;
			cur_ff.rdata <= jumperless_setting_reset;
			cur_ff.srst <= 1'b0;
		end
		else if (ce)
			cur_ff <= nxt_cur;
	end

	// outputs straight from the state flops
	assign rd_data = cur_ff.rdata;
	assign soft_reset = cur_ff.srst;
	assign irq_channel_sel = cur_ff.irq_sel;
	assign io_window_sel = cur_ff.io_sel;

	// checks watch only the registered outputs, one enabled edge after the request
	// the clock enable sits in every request antecedent, not in the cause, keep and reset checks, because a frozen edge takes nothing

	// a reset port write in isa mode pulses soft reset on the next cycle
	a_reset_pulse: assert property (@(posedge clock) disable iff (rst)
		(ce && wr && isa_mode && is_reset_port(addr))
		|=> soft_reset)
		else $error("reset port write gave no soft reset");

	// outside isa mode the reset ports are dead
	a_reset_isa_only: assert property (@(posedge clock) disable iff (rst)
		(ce && wr && !isa_mode)
		|=> !soft_reset)
		else $error("soft reset outside ISA mode");

	// writes below the reset page never reset anything
	a_reset_addr_only: assert property (@(posedge clock) disable iff (rst)
		(ce && wr && !is_reset_port(addr))
		|=> !soft_reset)
		else $error("soft reset from a non reset address");

	// the pulse is one cycle unless another port write follows at once
	a_pulse_single: assert property (@(posedge clock) disable iff (rst)
		(ce && !wr)
		|=> !soft_reset)
		else $error("soft reset pulse too long");

	// a rising pulse must trace back to an accepted port write
	a_pulse_cause: assert property (@(posedge clock) disable iff (rst)
		$rose(soft_reset)
		|-> $past(wr) && $past(isa_mode) && is_reset_port($past(addr)))
		else $error("soft reset without a port write");

	// io window steps by one on each enabled cycling read
	a_io_step: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load && rd && jumperless_mode && is_io_base(addr))
		|=> io_window_sel == $past(io_window_sel) + 3'h1)
		else $error("io window did not step on read");

	// the three-bit window wraps from the last code back to the first
	a_step_wraps: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load && rd && jumperless_mode && is_io_base(addr) && io_window_sel == 3'h7)
		|=> io_window_sel == 3'h0)
		else $error("io window did not wrap");

	// cycling reads are refused outside jumperless mode
	a_io_jumper_hold: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load && !jumperless_mode)
		|=> $stable(io_window_sel))
		else $error("io window stepped outside jumperless mode");

	// nothing but a cycling read or a load moves the io window
	a_io_hold: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load && !(rd && is_io_base(addr)))
		|=> $stable(io_window_sel))
		else $error("io window moved without a cycling read");

	// the cycling port itself reads back as a constant with no meaning
	a_io_base_data: assert property (@(posedge clock) disable iff (rst)
		(ce && rd && is_io_base(addr))
		|=> rd_data == io_base_read_value)
		else $error("cycling port returned data");

	// a soft reset leaves both selections where they were
	a_keep_sel: assert property (@(posedge clock) disable iff (rst)
		(soft_reset && !$past(init_load) && !$past(rd))
		|-> $stable(irq_channel_sel) && $stable(io_window_sel))
		else $error("soft reset disturbed selections");

	// the setting register is read-only; writes leave it alone
	a_write_ignored: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load && wr && !rd)
		|=> $stable(irq_channel_sel) && $stable(io_window_sel))
		else $error("write changed the selections");

	// setting read shows interrupt index high, io code low
	a_setting_read: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load && rd && is_setting(addr))
		|=> rd_data == {$past(irq_channel_sel), 3'h0, $past(io_window_sel)})
		else $error("setting read wrong");

	// unused middle bits always read zero, so software may mask loosely
	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		(ce && rd && is_setting(addr))
		|=> rd_data[irq_sel_lsb - 1:io_sel_msb + 1] == 3'h0)
		else $error("reserved setting bits not zero");

	// addresses outside the two registers read as zero
	a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
		(ce && rd && !is_io_base(addr) && !is_setting(addr))
		|=> rd_data == 8'h00)
		else $error("unmapped read returned data");

	// read data stands one cycle and then drops back to zero
	a_idle_data_zero: assert property (@(posedge clock) disable iff (rst)
		(ce && !rd)
		|=> rd_data == 8'h00)
		else $error("read data outlived its cycle");

	// power-up interrupt selection is captured on load
	a_init_load: assert property (@(posedge clock) disable iff (rst)
		(ce && init_load)
		|=> irq_channel_sel == $past(init_irq_sel))
		else $error("power-up selection not captured");

	// power-up io window selection is captured on load
	a_init_load_io: assert property (@(posedge clock) disable iff (rst)
		(ce && init_load)
		|=> io_window_sel == $past(init_io_sel))
		else $error("power-up io window not captured");

	// only a load moves the interrupt selection
	a_irq_hold: assert property (@(posedge clock) disable iff (rst)
		(ce && !init_load)
		|=> $stable(irq_channel_sel))
		else $error("interrupt selection moved");

	// hard reset clears every output, whatever the clock enable did
	a_after_reset: assert property (@(posedge clock) disable iff (rst)
		$past(rst)
		|-> rd_data == jumperless_setting_reset && !soft_reset
			&& irq_channel_sel == irq_sel_reset && io_window_sel == io_sel_reset)
		else $error("hard reset left state behind");

	// a low clock enable freezes every flop
	a_freeze_state: assert property (@(posedge clock) disable iff (rst) // clock enable
		!ce
		|=> $stable(rd_data) && $stable(soft_reset)
			&& $stable(irq_channel_sel) && $stable(io_window_sel))
		else $error("state moved while clock enable low");
endmodule

/* File: rtl/jumperless_cfg_pkg.sv */
// constants for the jumperless setting and soft reset register block
package jumperless_cfg_pkg;
	localparam logic [4:0] io_base_cycling_addr = 5'h12;
	localparam logic [4:0] jumperless_setting_addr = 5'h13;
	localparam logic [1:0] soft_reset_page = 2'h3; // address bits 4:3 of the reset ports
	localparam logic [7:0] jumperless_setting_reset = 8'h00;
	localparam int irq_sel_lsb = 6;
	localparam int irq_sel_msb = 7;
	localparam int io_sel_lsb = 0;
	localparam int io_sel_msb = 2;
	localparam logic [2:0] io_sel_reset = 3'h0;
	localparam logic [1:0] irq_sel_reset = 2'h0;
	localparam logic [2:0] io_sel_step = 3'h1;
	localparam logic [7:0] io_base_read_value = 8'h00;
	localparam int soft_reset_time_ns = 4;
	localparam int clock_period_ns = 4;
	localparam int soft_reset_cycles = (soft_reset_time_ns + clock_period_ns - 1) / clock_period_ns;
endpackage

/* File: verification/isa_host.sv */
// isa host model giving one-cycle register strobes
`timescale 1ns/1ps
module isa_host (
	input wire logic clock,
	output logic [4:0] addr = 5'h00,
	output logic rd = 1'h0,
	output logic wr = 1'h0
);
	task automatic access(input logic w, input logic [4:0] a);
		@(posedge clock);
		#1 {addr, rd, wr} = {a, ~w, w};
		@(posedge clock);
		#1 {addr, rd, wr} = {~a, 2'h0}; // idle address inverted, never stale
	endtask
endmodule

/* File: verification/tb.sv */
// bench for the jumperless setting and soft reset block
`timescale 1ns/1ps
module tb;
	import jumperless_cfg_pkg::*;
	logic clock = 1'h0, rst = 1'h1, isa_mode = 1'h1, jumperless_mode = 1'h1, init_load = 1'h1;
	logic rd, wr, soft_reset, ce = 1'h1;
	logic [1:0] init_irq_sel = 2'h3, irq_channel_sel;
	logic [2:0] init_io_sel = 3'h7, io_window_sel;
	logic [4:0] addr;
	logic [7:0] rd_data;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	always #2 clock = ~clock;
	// hang guard: the run needs about 53 cycles, a stall counts as a mismatch
	always @(posedge clock)
	begin
		if (++cycles == 400)
		begin
			mismatches++;
			wrap_up();
		end
	end
	isa_jumperless_config_reset dut (.*);
	isa_host host (.*);
	task automatic chk(input logic ok, input string what);
		samples_checked++;
		if (!ok)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic wrap_up;
		if (mismatches == 0 && samples_checked > 0 && cycles < 400)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic sel_scenario; // power-up interrupt selection shown, io base read wraps 7 to 0
		@(posedge clock);
		#1 init_load = 1'h0;
		host.access(1'h0, io_base_cycling_addr);
		host.access(1'h0, jumperless_setting_addr);
		chk(rd_data === 8'hC0, "setting readback");
	endtask
	task automatic refused_scenario; // no step outside jumperless, nothing off the map
		jumperless_mode = 1'h0;
		host.access(1'h0, io_base_cycling_addr);
		chk(io_window_sel === 3'h0, "io window stepped in jumper mode");
		jumperless_mode = 1'h1;
		host.access(1'h0, 5'h10);
		chk(rd_data === 8'h00, "unmapped read data");
		host.access(1'h1, jumperless_setting_addr);
		chk(soft_reset === 1'h0 && io_window_sel === 3'h0, "setting written");
	endtask
	task automatic freeze_scenario; // low clock enable takes neither a read nor a reset write
		ce = 1'h0;
		host.access(1'h0, io_base_cycling_addr);
		host.access(1'h1, {soft_reset_page, 3'h5});
		chk(soft_reset === 1'h0 && io_window_sel === 3'h0, "frozen state moved");
		ce = 1'h1;
	endtask
	task automatic reset_ports; // pulse in isa mode only, selections kept
		for (int p = 0; p < 16; p++)
		begin
			isa_mode = ~p[3];
			host.access(1'h1, {soft_reset_page, p[2:0]});
			chk(soft_reset === isa_mode && {irq_channel_sel, io_window_sel} === 5'h18, "reset port");
		end
	endtask
	task automatic rerun_reset; // hard reset in mid-run clears the selections
		rst = 1'h1;
		@(posedge clock);
		#1 rst = 1'h0;
		host.access(1'h0, jumperless_setting_addr);
		chk(rd_data === 8'h00 && io_window_sel === 3'h0, "hard reset value");
	endtask
	initial
	begin
		repeat (3) @(posedge clock);
		#1 rst = 1'h0;
		sel_scenario();
		refused_scenario();
		freeze_scenario();
		reset_ports();
		rerun_reset();
		wrap_up();
	end
endmodule
